// [common/ecd_pkg.sv]
/*
 * Types for the opcode decoder. Assumes the constants header beside it.
 */
package ecd_pkg;
    // Operation class
    typedef enum logic [4:0] {
        OP_NONE, OP_ADD, OP_ADD_CARRY, OP_INC, OP_DEC, OP_SUB,
        OP_SUB_BORROW, OP_CMP, OP_NEG, OP_NOT, OP_CHAR_ADJ_ADD,
        OP_DEC_ADJ_ADD, OP_CHAR_ADJ_SUB, OP_DEC_ADJ_SUB, OP_MUL, OP_XOR,
        OP_STR_MOVE, OP_STR_CMP, OP_STR_SCAN, OP_STR_LOAD, OP_STR_STORE,
        OP_CALL, OP_JMP, OP_ILLEGAL
    } ecd_op_t;
    // Segment choice: extra, code, stack, data
    typedef enum logic [1:0] {
        SEG_EXTRA, SEG_CODE, SEG_STACK, SEG_DATA
    } ecd_seg_t;
endpackage

// [common/ecd_regs.svh]
/*
 * Constants for the opcode decoder: opcode patterns, field values and
 * minimum clock counts. Assumes byte-wide opcodes from a prefetch queue.
 */
`ifndef ECD_REGS_SVH
`define ECD_REGS_SVH

// Segment override prefixes
`define ECD_PFX_CODE 8'h2E
`define ECD_PFX_STACK 8'h36
`define ECD_PFX_DATA 8'h3E
`define ECD_PFX_EXTRA 8'h26
// Repeat prefixes (low bit is the z flag)
`define ECD_PFX_REP 8'hF2
`define ECD_PFX_REP_HI7 7'h79
// Single byte opcodes
`define ECD_OP_CHAR_ADJ_ADD 8'h37
`define ECD_OP_DEC_ADJ_ADD 8'h27
`define ECD_OP_CHAR_ADJ_SUB 8'h3F
`define ECD_OP_DEC_ADJ_SUB 8'h2F
`define ECD_OP_CALL_NEAR 8'hE8
`define ECD_OP_CALL_FAR 8'h9A
`define ECD_OP_JMP_NEAR 8'hE9
`define ECD_OP_JMP_FAR 8'hEA
`define ECD_OP_JMP_SHORT 8'hEB
`define ECD_OP_GRP_FF 8'hFF
// Field positions
`define ECD_W_BIT 0
`define ECD_D_BIT 1
`define ECD_S_BIT 1
// Minimum clock counts and maximum spans
`define ECD_CLK_RM_REG 8'h03
`define ECD_CLK_RM_MEM 8'h0A
`define ECD_CLK_INCDEC_MEM 8'h0F
`define ECD_CLK_INC_SHORT 8'h03
`define ECD_CLK_IMM_REG 8'h04
`define ECD_CLK_IMM_MEM 8'h10
`define ECD_CLK_NEG 8'h03
`define ECD_CLK_MUL_RB 8'h1A
`define ECD_CLK_MUL_RW 8'h23
`define ECD_CLK_MUL_MB 8'h20
`define ECD_CLK_MUL_MW 8'h29
`define ECD_CLK_MUL_SPAN 8'h02
`define ECD_CLK_ADJ_ADD 8'h08
`define ECD_CLK_DADJ 8'h04
`define ECD_CLK_ADJ_SUB 8'h07
`define ECD_CLK_STR_MOVE 8'h0E
`define ECD_CLK_STR_CMP 8'h16
`define ECD_CLK_STR_SCAN 8'h0F
`define ECD_CLK_STR_LOAD 8'h0C
`define ECD_CLK_STR_STORE 8'h0A
`define ECD_CLK_REP_MOVE_BASE 8'h08
`define ECD_CLK_REP_MOVE_STEP 8'h08
`define ECD_CLK_CALL_NEAR 8'h0F
`define ECD_CLK_CALL_FAR 8'h17
`define ECD_CLK_CALL_IND 8'h0D
`define ECD_CLK_CALL_FAR_IND 8'h26
`define ECD_CLK_JMP 8'h0E
`define ECD_CLK_JMP_IND 8'h0B
`define ECD_CLK_JMP_FAR_IND 8'h1A
`define ECD_CLK_EA 8'h04
`define ECD_CLK_HANDSHAKE_MAX 8'h02

`endif

// [core/ecd_clk_calc.sv]
/*
 * Repeated string move timing: 8 plus 8 per iteration. Assumes a
 * 16-bit count register value at the input.
 */
`timescale 1ns/10ps
`include "ecd_regs.svh"

module ecd_clk_calc (
    // Count
    input wire logic [15:0] i_count,
    // Result
    output logic [19:0] o_clocks
);
    assign o_clocks = 20'(`ECD_CLK_REP_MOVE_BASE) +
        {1'b0, i_count, 3'h0};
endmodule // ecd_clk_calc

// [core/ecd_decoder.sv]
/*
 * Opcode decoder: consumes bytes from the prefetch queue, tracks prefixes,
 * classifies the instruction and reports its minimum clock count and
 * operand segment. Assumes the queue offers one byte per valid cycle.
 */
`timescale 1ns/10ps
`include "ecd_regs.svh"

module ecd_decoder (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_clk_en,
    // Prefetch queue byte and count register value
    input wire logic i_byte_valid,
    input wire logic [7:0] i_byte,
    input wire logic [15:0] i_count_reg,
    // Decode result
    output logic o_valid,
    output ecd_pkg::ecd_op_t o_op,
    output logic o_word,
    output logic o_dir_to_reg,
    output logic o_sign_ext,
    output logic o_mem_operand,
    output logic o_direct_disp,
    output ecd_pkg::ecd_seg_t o_seg,
    output logic o_seg_ovr,
    output logic o_repeat,
    output logic o_repeat_z,
    output logic [7:0] o_min_clocks,
    output logic [7:0] o_max_clocks,
    output logic [19:0] o_rep_clocks
);
    typedef enum logic [1:0] {ST_OPCODE, ST_MODRM} ecd_state_t;

    ecd_state_t state;
    logic [7:0] opc;
    logic ovr_valid;
    ecd_pkg::ecd_seg_t ovr_seg;
    logic rep_valid;
    logic rep_z;

    // Reg field helper, used for several groups
    function automatic logic reg_is(input logic [7:0] m,
                                    input logic [2:0] r);
        reg_is = (m[5:3] == r);
    endfunction

    wire take = i_clk_en && i_byte_valid;
    wire [7:0] b = i_byte;

    wire is_pfx_c = (b == `ECD_PFX_CODE);
    wire is_pfx_s = (b == `ECD_PFX_STACK);
    wire is_pfx_d = (b == `ECD_PFX_DATA);
    wire is_pfx_e = (b == `ECD_PFX_EXTRA);
    wire is_ovr = is_pfx_c | is_pfx_s | is_pfx_d | is_pfx_e;
    wire ecd_pkg::ecd_seg_t pfx_seg = is_pfx_c ? ecd_pkg::SEG_CODE :
        is_pfx_s ? ecd_pkg::SEG_STACK :
        is_pfx_d ? ecd_pkg::SEG_DATA : ecd_pkg::SEG_EXTRA;
    wire is_rep = (b[7:1] == `ECD_PFX_REP_HI7);

    // Opcodes that need a mod/reg/rm byte
    wire needs_modrm =
        (b[7:2] == 6'h00) || (b[7:2] == 6'h04) || (b[7:2] == 6'h0A) ||
        (b[7:2] == 6'h06) || (b[7:2] == 6'h0C) || (b[7:1] == 7'h1D) ||
        (b[7:1] == 7'h1C) || (b[7:2] == 6'h20) || (b[7:1] == 7'h7F) ||
        (b[7:1] == 7'h7B);

    // Single byte decode
    logic [7:0] sb_clk;
    ecd_pkg::ecd_op_t sb_op;
    always_comb begin
        sb_op = ecd_pkg::OP_ILLEGAL;
        sb_clk = 8'h00;
        if (b[7:3] == 5'h08) begin
            sb_op = ecd_pkg::OP_INC;
            sb_clk = `ECD_CLK_INC_SHORT;
        end else if (b[7:3] == 5'h09) begin
            sb_op = ecd_pkg::OP_DEC;
            sb_clk = `ECD_CLK_INC_SHORT;
        end else begin
            case (b)
                `ECD_OP_CHAR_ADJ_ADD: begin
                    sb_op = ecd_pkg::OP_CHAR_ADJ_ADD;
                    sb_clk = `ECD_CLK_ADJ_ADD;
                end
                `ECD_OP_DEC_ADJ_ADD: begin
                    sb_op = ecd_pkg::OP_DEC_ADJ_ADD;
                    sb_clk = `ECD_CLK_DADJ;
                end
                `ECD_OP_CHAR_ADJ_SUB: begin
                    sb_op = ecd_pkg::OP_CHAR_ADJ_SUB;
                    sb_clk = `ECD_CLK_ADJ_SUB;
                end
                `ECD_OP_DEC_ADJ_SUB: begin
                    sb_op = ecd_pkg::OP_DEC_ADJ_SUB;
                    sb_clk = `ECD_CLK_DADJ;
                end
                `ECD_OP_CALL_NEAR: begin
                    sb_op = ecd_pkg::OP_CALL;
                    sb_clk = `ECD_CLK_CALL_NEAR;
                end
                `ECD_OP_CALL_FAR: begin
                    sb_op = ecd_pkg::OP_CALL;
                    sb_clk = `ECD_CLK_CALL_FAR;
                end
                `ECD_OP_JMP_SHORT, `ECD_OP_JMP_NEAR,
                `ECD_OP_JMP_FAR: begin
                    sb_op = ecd_pkg::OP_JMP;
                    sb_clk = `ECD_CLK_JMP;
                end
                default: begin
                    sb_op = ecd_pkg::OP_ILLEGAL;
                    sb_clk = 8'h00;
                end
            endcase
            case (b[7:1])
                7'h02: sb_op = ecd_pkg::OP_ADD;
                7'h0A: sb_op = ecd_pkg::OP_ADD_CARRY;
                7'h16: sb_op = ecd_pkg::OP_SUB;
                7'h0E: sb_op = ecd_pkg::OP_SUB_BORROW;
                7'h1E: sb_op = ecd_pkg::OP_CMP;
                7'h1A: sb_op = ecd_pkg::OP_XOR;
                7'h52: sb_op = ecd_pkg::OP_STR_MOVE;
                7'h53: sb_op = ecd_pkg::OP_STR_CMP;
                7'h57: sb_op = ecd_pkg::OP_STR_SCAN;
                7'h56: sb_op = ecd_pkg::OP_STR_LOAD;
                7'h55: sb_op = ecd_pkg::OP_STR_STORE;
                default: sb_op = sb_op;
            endcase
            case (b[7:1])
                7'h02, 7'h0A, 7'h16, 7'h0E, 7'h1E, 7'h1A:
                    sb_clk = `ECD_CLK_IMM_REG;
                7'h52: sb_clk = `ECD_CLK_STR_MOVE;
                7'h53: sb_clk = `ECD_CLK_STR_CMP;
                7'h57: sb_clk = `ECD_CLK_STR_SCAN;
                7'h56: sb_clk = `ECD_CLK_STR_LOAD;
                7'h55: sb_clk = `ECD_CLK_STR_STORE;
                default: sb_clk = sb_clk;
            endcase
        end
    end

    // Second byte decode for mod/reg/rm forms
    wire is_reg_op = (b[7:6] == 2'h3);
    wire is_mem = !is_reg_op;
    logic [7:0] mr_clk;
    ecd_pkg::ecd_op_t mr_op;
    always_comb begin
        mr_op = ecd_pkg::OP_ILLEGAL;
        mr_clk = is_mem ? `ECD_CLK_RM_MEM : `ECD_CLK_RM_REG;
        case (opc[7:2])
            6'h00: mr_op = ecd_pkg::OP_ADD;
            6'h04: mr_op = ecd_pkg::OP_ADD_CARRY;
            6'h0A: mr_op = ecd_pkg::OP_SUB;
            6'h06: mr_op = ecd_pkg::OP_SUB_BORROW;
            6'h0C: mr_op = ecd_pkg::OP_XOR;
            6'h0E: mr_op = ecd_pkg::OP_CMP;
            // Immediate group, 1000000w only for xor
            6'h20: begin
                mr_clk = is_mem ? `ECD_CLK_IMM_MEM : `ECD_CLK_IMM_REG;
                if (reg_is(b, 3'h0))
                    mr_op = ecd_pkg::OP_ADD;
                else if (reg_is(b, 3'h2))
                    mr_op = ecd_pkg::OP_ADD_CARRY;
                else if (reg_is(b, 3'h5))
                    mr_op = ecd_pkg::OP_SUB;
                else if (reg_is(b, 3'h3))
                    mr_op = ecd_pkg::OP_SUB_BORROW;
                else if (reg_is(b, 3'h7))
                    mr_op = ecd_pkg::OP_CMP;
                else if (reg_is(b, 3'h6) && !opc[`ECD_S_BIT])
                    mr_op = ecd_pkg::OP_XOR;
            end
            6'h3D: if (opc[1]) begin
                if (reg_is(b, 3'h3)) begin
                    mr_op = ecd_pkg::OP_NEG;
                    mr_clk = is_mem ? `ECD_CLK_RM_MEM : `ECD_CLK_NEG;
                end else if (reg_is(b, 3'h2))
                    mr_op = ecd_pkg::OP_NOT;
                else if (reg_is(b, 3'h4)) begin
                    mr_op = ecd_pkg::OP_MUL;
                    mr_clk = is_mem ?
                        (opc[0] ? `ECD_CLK_MUL_MW : `ECD_CLK_MUL_MB) :
                        (opc[0] ? `ECD_CLK_MUL_RW : `ECD_CLK_MUL_RB);
                end
            end
            6'h3F: if (opc[1]) begin
                mr_clk = is_mem ? `ECD_CLK_INCDEC_MEM : `ECD_CLK_RM_REG;
                if (reg_is(b, 3'h0))
                    mr_op = ecd_pkg::OP_INC;
                else if (reg_is(b, 3'h1))
                    mr_op = ecd_pkg::OP_DEC;
                else if (opc[0] && reg_is(b, 3'h2)) begin
                    mr_op = ecd_pkg::OP_CALL;
                    mr_clk = `ECD_CLK_CALL_IND;
                end else if (opc[0] && reg_is(b, 3'h4)) begin
                    mr_op = ecd_pkg::OP_JMP;
                    mr_clk = `ECD_CLK_JMP_IND;
                end else if (opc[0] && reg_is(b, 3'h3) && is_mem) begin
                    mr_op = ecd_pkg::OP_CALL;
                    mr_clk = `ECD_CLK_CALL_FAR_IND;
                end else if (opc[0] && reg_is(b, 3'h5) && is_mem) begin
                    mr_op = ecd_pkg::OP_JMP;
                    mr_clk = `ECD_CLK_JMP_FAR_IND;
                end
            end
            default: mr_op = ecd_pkg::OP_ILLEGAL;
        endcase
    end

    // address time is inside the listed counts, nothing added
    // memory forms may run two clocks past the minimum; multiply adds two more in both forms
    wire [7:0] mr_max = is_mem ? mr_clk + `ECD_CLK_HANDSHAKE_MAX : mr_clk;
    wire is_mul_op = (mr_op == ecd_pkg::OP_MUL);
    wire [7:0] mr_max_all = is_mul_op ? mr_max + `ECD_CLK_MUL_SPAN : mr_max;

    // String destination through the destination index register
    wire sb_str = (sb_op == ecd_pkg::OP_STR_MOVE) ||
        (sb_op == ecd_pkg::OP_STR_STORE) ||
        (sb_op == ecd_pkg::OP_STR_SCAN) || (sb_op == ecd_pkg::OP_STR_CMP);
    wire sb_mem = sb_str || (sb_op == ecd_pkg::OP_STR_LOAD);

    ecd_pkg::ecd_seg_t seg_mr;
    ecd_pkg::ecd_seg_t seg_str;
    logic direct_mr;
    ecd_seg_sel u_seg_mr (
        .i_mod(b[7:6]),
        .i_rm(b[2:0]),
        .i_is_dest_string(1'b0),
        .i_ovr_valid(ovr_valid),
        .i_ovr_seg(ovr_seg),
        .o_seg(seg_mr),
        .o_direct_disp(direct_mr)
    );
    ecd_seg_sel u_seg_str (
        .i_mod(2'h0),
        .i_rm(3'h4),
        .i_is_dest_string(sb_str),
        .i_ovr_valid(ovr_valid),
        .i_ovr_seg(ovr_seg),
        .o_seg(seg_str),
        .o_direct_disp()
    );
    logic [19:0] rep_clk;
    ecd_clk_calc u_rep (
        .i_count(i_count_reg),
        .o_clocks(rep_clk)
    );

    wire first_done = (state == ST_OPCODE) && !is_ovr && !is_rep &&
        !needs_modrm;
    wire second_done = (state == ST_MODRM);
    wire rep_move = rep_valid && (sb_op == ecd_pkg::OP_STR_MOVE);

    // Sequencer and prefix memory
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            state <= ST_OPCODE;
            opc <= 8'h00;
            ovr_valid <= 1'b0;
            ovr_seg <= ecd_pkg::SEG_DATA;
            rep_valid <= 1'b0;
            rep_z <= 1'b0;
        end else if (take) begin
            case (state)
                ST_OPCODE: begin
                    if (is_ovr) begin
                        ovr_valid <= 1'b1;
                        ovr_seg <= pfx_seg;
                    end else if (is_rep) begin
                        rep_valid <= 1'b1;
                        rep_z <= b[0];
                    end else if (needs_modrm) begin
                        opc <= b;
                        state <= ST_MODRM;
                    end else begin
                        ovr_valid <= 1'b0;
                        rep_valid <= 1'b0;
                    end
                end
                ST_MODRM: begin
                    state <= ST_OPCODE;
                    ovr_valid <= 1'b0;
                    rep_valid <= 1'b0;
                end
                default: state <= ST_OPCODE;
            endcase
        end
    end

    // Registered result, one pulse per instruction
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            o_valid <= 1'b0;
            o_op <= ecd_pkg::OP_NONE;
            o_word <= 1'b0;
            o_dir_to_reg <= 1'b0;
            o_sign_ext <= 1'b0;
            o_mem_operand <= 1'b0;
            o_direct_disp <= 1'b0;
            o_seg <= ecd_pkg::SEG_DATA;
            o_seg_ovr <= 1'b0;
            o_repeat <= 1'b0;
            o_repeat_z <= 1'b0;
            o_min_clocks <= 8'h00;
            o_max_clocks <= 8'h00;
            o_rep_clocks <= 20'h00000;
        end else if (i_clk_en) begin
            o_valid <= take && (first_done || second_done);
            if (take && second_done) begin
                o_op <= mr_op;
                o_word <= opc[`ECD_W_BIT];
                o_dir_to_reg <= opc[`ECD_D_BIT] && (opc[7:6] == 2'h0);
                o_sign_ext <= opc[`ECD_S_BIT] && (opc[7:2] == 6'h20);
                o_mem_operand <= is_mem;
                o_direct_disp <= direct_mr;
                o_seg <= seg_mr;
                o_seg_ovr <= ovr_valid;
                o_repeat <= 1'b0;
                o_repeat_z <= 1'b0;
                o_min_clocks <= mr_clk;
                o_max_clocks <= mr_max_all;
                o_rep_clocks <= 20'h00000;
            end else if (take && first_done) begin
                o_op <= sb_op;
                o_word <= b[`ECD_W_BIT];
                o_dir_to_reg <= 1'b0;
                o_sign_ext <= 1'b0;
                o_mem_operand <= sb_mem;
                o_direct_disp <= 1'b0;
                o_seg <= seg_str;
                o_seg_ovr <= ovr_valid && !sb_str;
                o_repeat <= rep_valid && sb_mem;
                o_repeat_z <= rep_z;
                o_min_clocks <= sb_clk;
                o_max_clocks <= sb_mem ? sb_clk + `ECD_CLK_HANDSHAKE_MAX
                    : sb_clk;
                o_rep_clocks <= rep_move ? rep_clk : 20'h00000;
            end
        end
    end

    // Checks
    property p_short_inc;
        @(posedge i_clock) disable iff (!i_resetn)
        (i_clk_en && take && state == ST_OPCODE && b[7:4] == 4'h4)
        |=> (o_valid && o_min_clocks == 8'h03);
    endproperty
    a_short_inc: assert property (p_short_inc) else $error("inc time");
    property p_mul_range;
        @(posedge i_clock) disable iff (!i_resetn)
        (o_op == ecd_pkg::OP_MUL && o_valid)
        |-> (o_max_clocks == o_min_clocks + 8'h02 ||
             o_max_clocks == o_min_clocks + 8'h04);
    endproperty
    a_mul_range: assert property (p_mul_range) else $error("mul span");
    property p_str_dest;
        @(posedge i_clock) disable iff (!i_resetn)
        (o_valid && o_op == ecd_pkg::OP_STR_MOVE)
        |-> (o_seg == ecd_pkg::SEG_EXTRA);
    endproperty
    a_str_dest: assert property (p_str_dest) else $error("dest seg");
    property p_jmp_time;
        @(posedge i_clock) disable iff (!i_resetn)
        (i_clk_en && take && state == ST_OPCODE &&
         b == `ECD_OP_JMP_SHORT) |=> (o_valid && o_min_clocks == 8'h0E);
    endproperty
    a_jmp_time: assert property (p_jmp_time) else $error("jmp time");
    property p_far_ind;
        @(posedge i_clock) disable iff (!i_resetn)
        (i_clk_en && take && state == ST_MODRM && opc == 8'hFF &&
         b[5:3] == 3'h5 && b[7:6] == 2'h3)
        |=> (o_op == ecd_pkg::OP_ILLEGAL);
    endproperty
    a_far_ind: assert property (p_far_ind) else $error("far ind");
    property p_direct;
        @(posedge i_clock) disable iff (!i_resetn)
        (o_valid && o_direct_disp) |-> o_mem_operand;
    endproperty
    a_direct: assert property (p_direct) else $error("direct");
    property p_pfx;
        @(posedge i_clock) disable iff (!i_resetn)
        (i_clk_en && take && state == ST_OPCODE && b == `ECD_PFX_STACK)
        |=> ovr_valid && ovr_seg == ecd_pkg::SEG_STACK && !o_valid;
    endproperty
    a_pfx: assert property (p_pfx) else $error("prefix");
    property p_rep;
        @(posedge i_clock) disable iff (!i_resetn)
        (o_valid && o_repeat && o_op == ecd_pkg::OP_STR_MOVE)
        |-> (o_rep_clocks == 20'(8) + {1'b0, $past(i_count_reg), 3'h0});
    endproperty
    a_rep: assert property (p_rep) else $error("rep time");
    c_mul: cover property (@(posedge i_clock) o_valid &&
        o_op == ecd_pkg::OP_MUL);
    c_rep: cover property (@(posedge i_clock) o_valid && o_repeat);
    c_call: cover property (@(posedge i_clock) o_valid &&
        o_op == ecd_pkg::OP_CALL);
endmodule // ecd_decoder

// [core/ecd_seg_sel.sv]
/*
 * Segment selector for the memory operand. Assumes mod and r/m from a
 * decoded operand byte and an optional pending override.
 */
`timescale 1ns/10ps
`include "ecd_regs.svh"

module ecd_seg_sel (
    // Operand fields
    input wire logic [1:0] i_mod,
    input wire logic [2:0] i_rm,
    input wire logic i_is_dest_string,
    // Override
    input wire logic i_ovr_valid,
    input wire ecd_pkg::ecd_seg_t i_ovr_seg,
    // Result
    output ecd_pkg::ecd_seg_t o_seg,
    output logic o_direct_disp
);
    // Direct displacement form bypasses register sums
    assign o_direct_disp = (i_mod == 2'h0) && (i_rm == 3'h6);
    // Base pointer forms: rm 010, 011, and 110 unless direct
    wire uses_base_ptr = (i_mod != 2'h3) &&
        ((i_rm == 3'h2) || (i_rm == 3'h3) ||
         ((i_rm == 3'h6) && !o_direct_disp));
    wire ecd_pkg::ecd_seg_t dflt_seg = uses_base_ptr ?
        ecd_pkg::SEG_STACK : ecd_pkg::SEG_DATA;
    assign o_seg = i_is_dest_string ? ecd_pkg::SEG_EXTRA :
        (i_ovr_valid ? i_ovr_seg : dflt_seg);
endmodule // ecd_seg_sel

// [verification/ecd_decoder_test.sv]
/* Self-checking bench for the opcode decoder.
   Assumes the queue model feeds bytes one per valid cycle. */
`timescale 1ns/10ps

module ecd_decoder_test;
    logic i_clock = 1'b0;
    logic i_resetn = 1'b0;
    logic [15:0] count = 16'h0000;
    logic clk_en = 1'b1;
    logic bv;
    logic [7:0] b;
    logic vld, wd, dr, se, mem, dd, so, rp, rz;
    ecd_pkg::ecd_op_t cls;
    ecd_pkg::ecd_seg_t seg;
    logic [7:0] mnc;
    logic [7:0] mxc;
    logic [19:0] rc;
    // Decode flags packed for one compare: word down to repeat z
    wire [7:0] flags = {wd, dr, se, mem, dd, so, rp, rz};
    int miscompares = 0;
    int num_checks = 0;
    always #5 i_clock = ~i_clock;
    ecd_queue_model m (.i_clock(i_clock), .o_valid(bv), .o_byte(b));
    ecd_decoder dut_u (.i_clock(i_clock), .i_resetn(i_resetn),
        .i_clk_en(clk_en), .i_byte_valid(bv), .i_byte(b),
        .i_count_reg(count), .o_valid(vld), .o_op(cls), .o_word(wd),
        .o_dir_to_reg(dr), .o_sign_ext(se), .o_mem_operand(mem),
        .o_direct_disp(dd), .o_seg(seg), .o_seg_ovr(so), .o_repeat(rp),
        .o_repeat_z(rz), .o_min_clocks(mnc), .o_max_clocks(mxc),
        .o_rep_clocks(rc));
    task results();
        $display("checks=%0d mismatches=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task chk(input logic [19:0] g, input logic [19:0] e);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Wait bounded for the decode pulse, then judge class and minimum
    task go(input ecd_pkg::ecd_op_t op, input logic [7:0] mn);
        int i;
        for (i = 0; i < 40; i++) begin
            @(posedge i_clock);
            #1;
            if (vld === 1'b1) break;
        end
        if (i == 40) begin
            miscompares++;
            results();
        end else begin
            chk({15'h0, cls}, {15'h0, op});
            chk({12'h0, mnc}, {12'h0, mn});
        end
    endtask
    task t_seg();
        m.push(8'h36); m.push(8'h01); m.push(8'h46);
        go(ecd_pkg::OP_ADD, 8'h0A);
        chk({18'h0, seg}, {18'h0, ecd_pkg::SEG_STACK});
        chk({12'h0, flags}, 20'h00094);
        chk({12'h0, mxc}, 20'h0000C);
        m.push(8'h02); m.push(8'h46);
        go(ecd_pkg::OP_ADD, 8'h0A);
        chk({18'h0, seg}, {18'h0, ecd_pkg::SEG_STACK});
        chk({12'h0, flags}, 20'h00050);
        m.push(8'h2A); m.push(8'h06);
        go(ecd_pkg::OP_SUB, 8'h0A);
        chk({19'h0, dd}, 20'h00001);
        chk({18'h0, seg}, {18'h0, ecd_pkg::SEG_DATA});
        $display("test seg done");
    endtask
    task t_short();
        m.push(8'h40); go(ecd_pkg::OP_INC, 8'h03);
        m.push(8'h4F); go(ecd_pkg::OP_DEC, 8'h03);
        m.push(8'h37); go(ecd_pkg::OP_CHAR_ADJ_ADD, 8'h08);
        m.push(8'h27); go(ecd_pkg::OP_DEC_ADJ_ADD, 8'h04);
        m.push(8'h3F); go(ecd_pkg::OP_CHAR_ADJ_SUB, 8'h07);
        m.push(8'h2F); go(ecd_pkg::OP_DEC_ADJ_SUB, 8'h04);
        $display("test short done");
    endtask
    task t_flow();
        m.slow = 1'b1;
        m.push(8'hF6); m.push(8'hE0); go(ecd_pkg::OP_MUL, 8'h1A);
        chk({12'h0, mxc}, 20'h0001C);
        m.push(8'hEB); go(ecd_pkg::OP_JMP, 8'h0E);
        m.push(8'hEA); go(ecd_pkg::OP_JMP, 8'h0E);
        m.push(8'h9A); go(ecd_pkg::OP_CALL, 8'h17);
        m.push(8'hFF); m.push(8'h1E); go(ecd_pkg::OP_CALL, 8'h26);
        m.push(8'hFF); m.push(8'hD8);
        go(ecd_pkg::OP_ILLEGAL, 8'h03);
        m.push(8'hFF); m.push(8'hE8);
        go(ecd_pkg::OP_ILLEGAL, 8'h03);
        m.slow = 1'b0;
        $display("test flow done");
    endtask
    task t_string();
        count = 16'h0003;
        m.push(8'hF2); m.push(8'hA4); go(ecd_pkg::OP_STR_MOVE, 8'h0E);
        chk(rc, 20'h00020);
        m.push(8'h2E); m.push(8'hAB); go(ecd_pkg::OP_STR_STORE, 8'h0A);
        chk({18'h0, seg}, {18'h0, ecd_pkg::SEG_EXTRA});
        chk({19'h0, so}, 20'h00000);
        m.push(8'hF3); m.push(8'hA6);
        go(ecd_pkg::OP_STR_CMP, 8'h16);
        chk({12'h0, flags}, 20'h00013);
        chk(rc, 20'h00000);
        m.push(8'hAE); go(ecd_pkg::OP_STR_SCAN, 8'h0F);
        m.push(8'h2E); m.push(8'hAC);
        go(ecd_pkg::OP_STR_LOAD, 8'h0C);
        chk({18'h0, seg}, {18'h0, ecd_pkg::SEG_CODE});
        $display("test string done");
    endtask
    // Remaining arithmetic, logic and control forms, register and memory
    task t_alu();
        m.push(8'h10); m.push(8'hC1);
        go(ecd_pkg::OP_ADD_CARRY, 8'h03);
        m.push(8'h1C); go(ecd_pkg::OP_SUB_BORROW, 8'h04);
        m.push(8'h38); m.push(8'hC8); go(ecd_pkg::OP_CMP, 8'h03);
        m.push(8'hF7); m.push(8'hD8); go(ecd_pkg::OP_NEG, 8'h03);
        m.push(8'hF7); m.push(8'h16); go(ecd_pkg::OP_NOT, 8'h0A);
        m.push(8'h80); m.push(8'hF0); go(ecd_pkg::OP_XOR, 8'h04);
        m.push(8'h34); go(ecd_pkg::OP_XOR, 8'h04);
        m.push(8'h83); m.push(8'hC0); go(ecd_pkg::OP_ADD, 8'h04);
        chk({12'h0, flags}, 20'h000A0);
        m.push(8'hFE); m.push(8'h08); go(ecd_pkg::OP_DEC, 8'h0F);
        m.push(8'hE8); go(ecd_pkg::OP_CALL, 8'h0F);
        m.push(8'hFF); m.push(8'hD0); go(ecd_pkg::OP_CALL, 8'h0D);
        m.push(8'hE9); go(ecd_pkg::OP_JMP, 8'h0E);
        $display("test alu done");
    endtask
    // Enable low must freeze the pulse; a reset drops a pending repeat
    task t_hold();
        m.push(8'h40); go(ecd_pkg::OP_INC, 8'h03);
        clk_en = 1'b0;
        repeat (3) begin
            @(posedge i_clock);
            #1;
            chk({19'h0, vld}, 20'h00001);
        end
        clk_en = 1'b1;
        @(posedge i_clock);
        #1;
        chk({19'h0, vld}, 20'h00000);
        m.push(8'hF2);
        repeat (3) @(posedge i_clock);
        #1 i_resetn = 1'b0;
        @(posedge i_clock);
        #1 i_resetn = 1'b1;
        chk({15'h0, cls}, {15'h0, ecd_pkg::OP_NONE});
        m.push(8'hA5); go(ecd_pkg::OP_STR_MOVE, 8'h0E);
        chk({12'h0, flags}, 20'h00090);
        $display("test hold done");
    endtask
    initial begin
        repeat (5) @(posedge i_clock);
        #1 i_resetn = 1'b1;
        t_seg();
        t_short();
        t_flow();
        t_string();
        t_alu();
        t_hold();
        results();
    end
endmodule // ecd_decoder_test

// [verification/ecd_queue_model.sv]
/* Prefetch queue model: offers queued bytes, one per cycle or with gaps.
   Assumes the bench pushes bytes through the push task. */
`timescale 1ns/10ps

module ecd_queue_model (
    // Clock
    input wire logic i_clock,
    // Byte offer
    output logic o_valid,
    output logic [7:0] o_byte
);
    logic [7:0] q[$];
    logic slow = 1'b0;
    logic gap = 1'b0;
    initial o_valid = 1'b0;
    initial o_byte = 8'h00;
    task push(input logic [7:0] b);
        q.push_back(b);
    endtask
    // Idle byte is scrambled so a decoder reading it unqualified shows up
    always @(posedge i_clock) begin
        #1;
        if (q.size() != 0 && !(slow && gap)) begin
            o_valid = 1'b1;
            o_byte = q.pop_front();
        end else begin
            o_valid = 1'b0;
            o_byte = ~o_byte;
        end
        gap = ~gap;
    end
endmodule // ecd_queue_model
